/* cpps_consts.svh */
// Register indices, field positions, reset values and stack sizing of the core registers
`ifndef CPPS_CONSTS_SVH
`define CPPS_CONSTS_SVH
`define CPPS_ADDR_LSB      2
`define CPPS_IDX_INDIRECT  6'h00
`define CPPS_IDX_TIMER     6'h01
`define CPPS_IDX_PCLOW     6'h02
`define CPPS_IDX_STATUS    6'h03
`define CPPS_IDX_POINTER   6'h04
`define CPPS_IDX_HIBUF     6'h0a
`define CPPS_PC_RESET      10'h3ff
`define CPPS_SP_LAST       3'h4
`define CPPS_STATUS_RESET  8'h18
`define CPPS_PTR_FILL      2'h3
`define CPPS_BUF_FILL      6'h00
`define CPPS_ST_WAKE       7
`define CPPS_ST_GP_HI      6
`define CPPS_ST_GP_LO      5
`define CPPS_ST_EXPIRY     4
`define CPPS_ST_SLEEP      3
`define CPPS_ST_ZERO       2
`define CPPS_ST_NIBBLE     1
`define CPPS_ST_CARRY      0
`endif

/* cpps_core_regs.sv */
// Core registers: indirect port, pointer, program counter, return stack, status flags
//
// Summary of operation
// RULE_01 - Indirect port reaches register chosen by pointer
// RULE_02 - Indirect port addressing itself reads zero
// RULE_03 - Self-addressed indirect write changes no register
// RULE_04 - Pointer low six bits select target
// RULE_05 - Pointer upper two bits read ones
// RULE_06 - Ten-bit counter, five-deep ten-bit stack
// RULE_07 - Low byte accessible; high bits via buffer
// RULE_08 - Counter advances each cycle unless loaded; the code advances it only on a cycle with instrValid set
// RULE_09 - Jump loads all ten bits; buffer kept
// RULE_10 - Call pushes return address, loads target
// RULE_11 - Returns pop counter; buffer kept
// RULE_12 - Low byte write takes buffer high bits
// RULE_13 - Buffer never loaded from counter
// RULE_14 - Flag-affecting instruction blocks status flag write
// RULE_15 - Expiry and sleep flags ignore software
// RULE_16 - Carry set on carry, on no borrow
// RULE_17 - Rotates load carry with shifted-out bit
// RULE_18 - Nibble carry from fourth bit
// RULE_19 - Zero flag follows result equal zero
// RULE_20 - Sleep flag set power-up/kick, cleared sleep
// RULE_21 - Expiry flag set power-up/kick/sleep, cleared overflow
// RULE_22 - Wake flag one after port-change wake
// RULE_23 - Reset loads counter with 3FFh
// RULE_24 - Full stack push overwrites oldest entry
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
`include "cpps_consts.svh"

module cpps_core_regs import cpps_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        instrValid,
  input  cpps_instr_t      instrOp,
  input  wire logic [9:0]  instrTarget,
  input  wire logic        aluStart,
  input  cpps_alu_t        aluOp,
  input  wire logic [7:0]  aluA,
  input  wire logic [7:0]  aluB,
  input  wire logic        wdtOverflow,
  input  wire logic        wakePortChange,
  input  wire logic        wakeOther,
  output logic      [9:0]  programCounter,
  output logic      [7:0]  statusFlags,
  output logic      [7:0]  aluResult
);

  logic [7:0] dataMem [0:63];
  logic [9:0] pc;
  logic [9:0] stack [0:4];
  logic [2:0] sp;
  logic [2:0] spPrev;
  logic [1:0] hiBuf;
  logic [5:0] pointer;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [5:0] busIdx;
  logic [5:0] tgt;
  logic       busWr;
  logic [7:0] wdata;
  logic [7:0] readValue;
  logic [7:0] opB;
  logic       cin;
  logic [8:0] sum;
  logic [4:0] half;
  logic [7:0] next_aluResult;
  logic       next_c;
  logic       affZ;
  logic       affDc;
  logic       affC;
  logic       aluTouches;
  logic       busWrPcl;
  logic       busWrStatus;
  logic       aluSrcMsb;
  logic       aluSrcLsb;

  // Indirect index is replaced by the pointer before any decode
  function automatic logic [5:0] cpps_target(input logic [5:0] idx, input logic [5:0] ptr);
    return (idx == `CPPS_IDX_INDIRECT) ? ptr : idx; // RULE_01 RULE_04
  endfunction

  // Addresses without a dedicated register fall through to plain storage
  function automatic logic cpps_is_plain(input logic [5:0] idx);
    return !(idx == `CPPS_IDX_INDIRECT || idx == `CPPS_IDX_PCLOW || idx == `CPPS_IDX_STATUS ||
             idx == `CPPS_IDX_POINTER || idx == `CPPS_IDX_HIBUF);
  endfunction

  assign busIdx      = avs_address[7:`CPPS_ADDR_LSB];
  assign tgt         = cpps_target(busIdx, pointer);
  assign wdata       = avs_writedata[7:0];
  assign busWr       = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign busWrPcl    = busWr && (tgt == `CPPS_IDX_PCLOW);
  assign busWrStatus = busWr && (tgt == `CPPS_IDX_STATUS);
  assign spPrev      = (sp == 3'h0) ? `CPPS_SP_LAST : 3'(sp - 3'h1);
  assign aluSrcMsb   = aluA[7];
  assign aluSrcLsb   = aluA[0];

  assign programCounter = pc;
  assign statusFlags    = status;

  always_comb begin
    case (tgt)
      `CPPS_IDX_INDIRECT: readValue = 8'h00; // RULE_02
      `CPPS_IDX_PCLOW:    readValue = pc[7:0]; // RULE_07
      `CPPS_IDX_STATUS:   readValue = status;
      `CPPS_IDX_POINTER:  readValue = {`CPPS_PTR_FILL, pointer}; // RULE_05
      `CPPS_IDX_HIBUF:    readValue = {`CPPS_BUF_FILL, hiBuf};
      default:            readValue = dataMem[tgt];
    endcase
  end

  // One wait state on every access keeps read data registered
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, readValue};
    end
  end

  // Self-addressed writes fall out of the plain check and do nothing
  always_ff @(posedge clk_sys) begin
    if (busWr && cpps_is_plain(tgt)) begin // RULE_03
      dataMem[tgt] <= wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pointer <= 6'h00;
    end else if (busWr && tgt == `CPPS_IDX_POINTER) begin
      pointer <= wdata[5:0]; // RULE_04
    end
  end

  // Only software fills the buffer; the counter never copies back
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hiBuf <= 2'h0;
    end else if (busWr && tgt == `CPPS_IDX_HIBUF) begin
      hiBuf <= wdata[1:0]; // RULE_13
    end
  end

  // A data write to the low byte is the instruction's destination and wins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pc <= `CPPS_PC_RESET; // RULE_23
    end else if (busWrPcl) begin
      pc <= {hiBuf, wdata}; // RULE_12 RULE_07
    end else if (instrValid) begin
      case (instrOp)
        CPPS_OP_JUMP:   pc <= instrTarget; // RULE_09
        CPPS_OP_CALL:   pc <= instrTarget; // RULE_10
        CPPS_OP_RETURN: pc <= stack[spPrev]; // RULE_11
        default:        pc <= 10'(pc + 10'h001); // RULE_08
      endcase
    end
  end

  // Circular stack: no overflow flag, oldest entry is lost when full
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sp <= 3'h0;
      for (int i = 0; i < 5; i++) begin
        stack[i] <= 10'h000;
      end
    end else if (instrValid && instrOp == CPPS_OP_CALL) begin
      stack[sp] <= pc; // RULE_06 RULE_10
      sp        <= (sp == `CPPS_SP_LAST) ? 3'h0 : 3'(sp + 3'h1); // RULE_24
    end else if (instrValid && instrOp == CPPS_OP_RETURN) begin
      sp <= spPrev; // RULE_11
    end
  end

  // Subtraction adds the two's complement, so carry means no borrow
  always_comb begin
    opB  = (aluOp == CPPS_ALU_SUB) ? ~aluB : aluB;
    cin  = (aluOp == CPPS_ALU_SUB);
    sum  = {1'b0, aluA} + {1'b0, opB} + {8'h00, cin}; // RULE_16
    half = {1'b0, aluA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin}; // RULE_18
    affZ  = 1'b0;
    affDc = 1'b0;
    affC  = 1'b0;
    next_c = status[`CPPS_ST_CARRY];
    next_aluResult = aluA;
    case (aluOp)
      CPPS_ALU_ADD, CPPS_ALU_SUB: begin
        next_aluResult = sum[7:0];
        next_c = sum[8]; // RULE_16
        affZ  = 1'b1;
        affDc = 1'b1;
        affC  = 1'b1;
      end
      CPPS_ALU_RLEFT: begin
        next_aluResult = {aluA[6:0], status[`CPPS_ST_CARRY]};
        next_c = aluSrcMsb; // RULE_17
        affC   = 1'b1;
      end
      CPPS_ALU_RRIGHT: begin
        next_aluResult = {status[`CPPS_ST_CARRY], aluA[7:1]};
        next_c = aluSrcLsb; // RULE_17
        affC   = 1'b1;
      end
      CPPS_ALU_LOGIC: begin
        affZ = 1'b1;
      end
      default: begin
        next_aluResult = aluA;
      end
    endcase
    aluTouches = aluStart && (affZ || affDc || affC);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      aluResult <= 8'h00;
    end else if (aluStart) begin
      aluResult <= next_aluResult;
    end
  end

  // Hardware sets are applied after clears so a coincident set wins
  always_comb begin
    next_status = status;
    if (busWrStatus) begin // RULE_15
      next_status[`CPPS_ST_GP_HI:`CPPS_ST_GP_LO] = wdata[`CPPS_ST_GP_HI:`CPPS_ST_GP_LO];
      if (!aluTouches) begin
        next_status[`CPPS_ST_ZERO:`CPPS_ST_CARRY] = wdata[`CPPS_ST_ZERO:`CPPS_ST_CARRY]; // RULE_14
      end
    end
    if (aluStart && affZ) begin
      next_status[`CPPS_ST_ZERO] = (next_aluResult == 8'h00); // RULE_19
    end
    if (aluStart && affDc) begin
      next_status[`CPPS_ST_NIBBLE] = half[4]; // RULE_18
    end
    if (aluStart && affC) begin
      next_status[`CPPS_ST_CARRY] = next_c;
    end
    // Expiry and sleep flags move only on these events
    if (wdtOverflow) begin
      next_status[`CPPS_ST_EXPIRY] = 1'b0; // RULE_21 RULE_15
    end
    if (instrValid && instrOp == CPPS_OP_SLEEP) begin
      next_status[`CPPS_ST_SLEEP]  = 1'b0; // RULE_20
      next_status[`CPPS_ST_EXPIRY] = 1'b1; // RULE_21
    end
    if (instrValid && instrOp == CPPS_OP_KICK) begin
      next_status[`CPPS_ST_SLEEP]  = 1'b1; // RULE_20
      next_status[`CPPS_ST_EXPIRY] = 1'b1; // RULE_21
    end
    if (wakeOther) begin
      next_status[`CPPS_ST_WAKE] = 1'b0; // RULE_22
    end
    if (wakePortChange) begin
      next_status[`CPPS_ST_WAKE] = 1'b1; // RULE_22
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      status <= `CPPS_STATUS_RESET; // RULE_20 RULE_21
    end else begin
      status <= next_status;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_self_read;
    avs_read && avs_waitrequest && busIdx == `CPPS_IDX_INDIRECT && pointer == 6'h00
      |=> avs_readdata == 32'h0000_0000;
  endproperty
  a_self_read: assert property (p_self_read) else $error("self indirect read not zero"); // RULE_02

  property p_pointer_fill;
    avs_read && avs_waitrequest && busIdx == `CPPS_IDX_POINTER |=> avs_readdata[7:6] == 2'h3;
  endproperty
  a_pointer_fill: assert property (p_pointer_fill) else $error("pointer top bits not ones"); // RULE_05

  property p_reset_vector;
    $past(reset) |-> pc == 10'h3ff;
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("counter not at vector"); // RULE_23

  property p_step;
    instrValid && instrOp == CPPS_OP_STEP && !busWrPcl |=> pc == 10'($past(pc) + 10'h001);
  endproperty
  a_step: assert property (p_step) else $error("counter did not advance"); // RULE_08

  property p_jump;
    instrValid && instrOp == CPPS_OP_JUMP && !busWrPcl |=> pc == $past(instrTarget) && $stable(hiBuf);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target not loaded"); // RULE_09

  sequence s_call;
    instrValid && instrOp == CPPS_OP_CALL && !busWrPcl;
  endsequence
  property p_call_return;
    s_call ##1 (instrValid && instrOp == CPPS_OP_RETURN && !busWrPcl) |=> pc == $past(pc, 2);
  endproperty
  a_call_return: assert property (p_call_return) else $error("return address lost"); // RULE_11

  property p_low_write;
    busWrPcl |=> pc == {$past(hiBuf), $past(wdata)};
  endproperty
  a_low_write: assert property (p_low_write) else $error("low byte write wrong"); // RULE_12

  property p_flag_block;
    busWrStatus && aluStart && aluOp == CPPS_ALU_ADD
      |=> status[2] == (8'($past(aluA) + $past(aluB)) == 8'h00);
  endproperty
  a_flag_block: assert property (p_flag_block) else $error("status write not blocked"); // RULE_14

  property p_flag_keep;
    busWrStatus && aluStart && aluOp == CPPS_ALU_RLEFT |=> status[2:1] == $past(status[2:1]);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("status write reached kept flags"); // RULE_14

  property p_sub_carry;
    aluStart && aluOp == CPPS_ALU_SUB |=> status[0] == ($past(aluA) >= $past(aluB));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("borrow sense wrong"); // RULE_16

  property p_rotate;
    aluStart && aluOp == CPPS_ALU_RLEFT |=> status[0] == $past(aluSrcMsb);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate carry wrong"); // RULE_17

  property p_sleep;
    instrValid && instrOp == CPPS_OP_SLEEP |=> !status[3] && status[4];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong"); // RULE_20

  property p_overflow;
    wdtOverflow && !(instrValid && (instrOp == CPPS_OP_SLEEP || instrOp == CPPS_OP_KICK))
      |=> !status[4];
  endproperty
  a_overflow: assert property (p_overflow) else $error("expiry flag not cleared"); // RULE_21

  c_call_return: cover property (s_call ##1 (instrValid && instrOp == CPPS_OP_RETURN));
  c_indirect_read: cover property (avs_read && !avs_waitrequest && busIdx == 6'h00);
  c_blocked_write: cover property (busWrStatus && aluTouches);
endmodule

/* cpps_core_regs_bench.sv */
// Self-checking bench for the core pointer, counter and status registers
`timescale 1ns/10ps
`include "cpps_consts.svh"

module cpps_core_regs_bench import cpps_pkg::*;;
  localparam logic [5:0] IP = `CPPS_IDX_INDIRECT;
  localparam logic [5:0] PL = `CPPS_IDX_PCLOW;
  localparam logic [5:0] ST = `CPPS_IDX_STATUS;
  localparam logic [5:0] PT = `CPPS_IDX_POINTER;
  localparam logic [5:0] HB = `CPPS_IDX_HIBUF;
  localparam logic [7:0] TA [4] = '{8'h0f, 8'hff, 8'h10, 8'h05};
  localparam logic [7:0] TB [4] = '{8'h01, 8'h01, 8'h01, 8'h05};
  localparam logic [7:0] RA [4] = '{8'h81, 8'h02, 8'h40, 8'h01};
  logic        clkSys;
  logic        reset;
  logic [7:0]  avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [31:0] avsWritedata;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic        instrValid;
  cpps_instr_t instrOp;
  logic [9:0]  instrTarget;
  logic        aluStart;
  cpps_alu_t   aluOp;
  logic [7:0]  aluA;
  logic [7:0]  aluB;
  logic        wdtOverflow;
  logic        wakePortChange;
  logic        wakeOther;
  logic [9:0]  programCounter;
  logic [7:0]  statusFlags;
  logic [7:0]  aluResult;
  logic [9:0]  expPc;
  logic [7:0]  expSt;
  logic [7:0]  expRes;
  logic [9:0]  stk [5];
  int          sp;
  int          nFail;
  int          samplesChecked;
  int          cycles;

  cpps_core_regs dut_u (
    .clk_sys(clkSys), .reset(reset), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(4'hf),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .instrValid(instrValid),
    .instrOp(instrOp), .instrTarget(instrTarget), .aluStart(aluStart), .aluOp(aluOp),
    .aluA(aluA), .aluB(aluB), .wdtOverflow(wdtOverflow), .wakePortChange(wakePortChange),
    .wakeOther(wakeOther), .programCounter(programCounter), .statusFlags(statusFlags),
    .aluResult(aluResult)
  );

  always #2.5 clkSys = ~clkSys;

  task automatic wrapUp();
    $display("checks %0d, mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clkSys) begin
    cycles++;
    if (cycles == 4000) begin
      nFail++;
      wrapUp();
    end
  end

  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic busAcc(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                        output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clkSys);
    avsAddress <= {idx, 2'b00};
    avsWritedata <= {24'h0, d};
    avsRead <= ~wr;
    avsWrite <= wr;
    do begin
      @(posedge clkSys);
      n++;
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata[7:0];
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    // Request edge, then one wait state before the answer
    check("bus latency", 10'h002, 10'(n));
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] q;
    busAcc(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] q;
    busAcc(1'b0, idx, 8'h00, q);
    check(what, {2'b0, exp}, {2'b0, q});
  endtask

  // One decoder cycle, then counter and flags against the running expectation
  task automatic step(input logic iv, input cpps_instr_t op, input logic [9:0] t,
                      input cpps_alu_t ao, input logic [7:0] a, input logic [7:0] b,
                      input logic [2:0] ev);
    @(posedge clkSys);
    instrValid <= iv;
    instrOp <= op;
    instrTarget <= t;
    aluStart <= (ao != CPPS_ALU_NONE);
    aluOp <= ao;
    aluA <= a;
    aluB <= b;
    {wdtOverflow, wakePortChange, wakeOther} <= ev;
    @(posedge clkSys);
    instrValid <= 1'b0;
    aluStart <= 1'b0;
    {wdtOverflow, wakePortChange, wakeOther} <= 3'b000;
    #1;
    check("programCounter", expPc, programCounter);
    check("statusFlags", {2'b0, expSt}, {2'b0, statusFlags});
  endtask

  task automatic inst(input cpps_instr_t op, input logic [9:0] t);
    step(1'b1, op, t, CPPS_ALU_NONE, 8'h00, 8'h00, 3'b000);
  endtask

  task automatic evt(input logic [2:0] ev);
    step(1'b0, CPPS_OP_STEP, 10'h0, CPPS_ALU_NONE, 8'h00, 8'h00, ev);
  endtask

  // Flags {zero, nibble carry, carry}; subtraction adds the complement plus one
  function automatic logic [2:0] addf(input logic [7:0] a, input logic [7:0] b,
                                      input logic sub);
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] h;
    bb = sub ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h0, sub};
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    return {s[7:0] == 8'h00, h[4], s[8]};
  endfunction

  initial begin
    {clkSys, reset, avsAddress, avsRead, avsWrite, avsWritedata} = {2'b01, 42'h0};
    {instrValid, instrTarget, aluStart, aluA, aluB} = 28'h0;
    instrOp = CPPS_OP_STEP;
    aluOp = CPPS_ALU_NONE;
    {wdtOverflow, wakePortChange, wakeOther} = 3'b000;
    {nFail, samplesChecked, cycles, sp} = '0;
    expPc = `CPPS_PC_RESET;
    expSt = `CPPS_STATUS_RESET;
    repeat (8) @(posedge clkSys);
    reset <= 1'b0;
    #1;
    check("programCounter", expPc, programCounter);
    rd(ST, expSt, "status");
    rd(PT, 8'hc0, "pointer");
    wr(6'h38, 8'h10);
    wr(6'h39, 8'h0a);
    wr(PT, 8'h38);
    rd(IP, 8'h10, "indirect");
    wr(PT, 8'h79);
    rd(PT, 8'hf9, "pointer");
    rd(IP, 8'h0a, "indirect");
    wr(PT, 8'h3f);
    wr(IP, 8'h5a);
    rd(6'h3f, 8'h5a, "register 3f");
    wr(PT, 8'h00);
    rd(IP, 8'h00, "indirect");
    wr(IP, 8'h77);
    rd(IP, 8'h00, "indirect");
    rd(6'h38, 8'h10, "register 38");
    rd(6'h3f, 8'h5a, "register 3f");
    expPc = 10'h000;
    inst(CPPS_OP_STEP, 10'h155);
    evt(3'b000);
    wr(HB, 8'h02);
    expPc = 10'h2a5;
    inst(CPPS_OP_JUMP, 10'h2a5);
    rd(PL, 8'ha5, "counter low byte");
    rd(HB, 8'h02, "high buffer");
    // Six calls on a five-deep stack: the oldest return address is lost
    for (int i = 0; i < 6; i++) begin
      stk[sp] = expPc;
      sp = (sp + 1) % 5;
      expPc = 10'h100 + 10'(i * 3);
      inst(CPPS_OP_CALL, expPc);
    end
    for (int i = 0; i < 5; i++) begin
      sp = (sp + 4) % 5;
      expPc = stk[sp];
      inst(CPPS_OP_RETURN, 10'h0);
    end
    // Call and return back to back: the pushed address comes straight back
    @(posedge clkSys);
    instrValid <= 1'b1;
    instrOp <= CPPS_OP_CALL;
    instrTarget <= 10'h3a0;
    @(posedge clkSys);
    instrOp <= CPPS_OP_RETURN;
    #1;
    check("programCounter", 10'h3a0, programCounter);
    @(posedge clkSys);
    instrValid <= 1'b0;
    #1;
    check("programCounter", expPc, programCounter);
    rd(HB, 8'h02, "high buffer");
    wr(PL, 8'h34);
    expPc = 10'h234;
    rd(PL, 8'h34, "counter low byte");
    check("programCounter", expPc, programCounter);
    expPc = 10'h235;
    inst(CPPS_OP_STEP, 10'h0);
    wr(HB, 8'h01);
    wr(PL, 8'hff);
    expPc = 10'h200;
    inst(CPPS_OP_STEP, 10'h0);
    rd(HB, 8'h01, "high buffer");
    expPc = expPc + 10'h1;
    expSt[4:3] = 2'b10;
    inst(CPPS_OP_SLEEP, 10'h0);
    expSt[4] = 1'b0;
    evt(3'b100);
    expPc = expPc + 10'h1;
    expSt[4] = 1'b1;
    inst(CPPS_OP_SLEEP, 10'h0);
    expPc = expPc + 10'h1;
    expSt[4:3] = 2'b11;
    inst(CPPS_OP_KICK, 10'h0);
    expSt[7] = 1'b1;
    evt(3'b010);
    wr(ST, 8'h00);
    expSt = {expSt[7], 2'b00, expSt[4:3], 3'b000};
    rd(ST, expSt, "status");
    expSt[7] = 1'b0;
    evt(3'b001);
    expPc = expPc + 10'h1;
    expSt[4:3] = 2'b10;
    inst(CPPS_OP_SLEEP, 10'h0);
    expSt[4] = 1'b0;
    evt(3'b100);
    wr(ST, 8'hff);
    expSt = {expSt[7], 2'b11, expSt[4:3], 3'b111};
    rd(ST, expSt, "status");
    // Status write lands on the same edge as an add that owns the arithmetic flags
    expSt = {expSt[7], 2'b00, expSt[4:3], addf(8'hff, 8'h01, 1'b0)};
    fork
      wr(ST, 8'h00);
      begin
        @(posedge clkSys);
        step(1'b0, CPPS_OP_STEP, 10'h0, CPPS_ALU_ADD, 8'hff, 8'h01, 3'b000);
      end
    join
    // A rotate owns only carry, yet zero and nibble carry must ignore the write too
    expSt = {expSt[7], 2'b00, expSt[4:3], expSt[2:1], 1'b0};
    fork
      wr(ST, 8'h00);
      begin
        @(posedge clkSys);
        step(1'b0, CPPS_OP_STEP, 10'h0, CPPS_ALU_RLEFT, 8'h7e, 8'h00, 3'b000);
      end
    join
    for (int i = 0; i < 8; i++) begin
      expSt[2:0] = addf(TA[i/2], TB[i/2], i[0]);
      step(1'b0, CPPS_OP_STEP, 10'h0, i[0] ? CPPS_ALU_SUB : CPPS_ALU_ADD,
           TA[i/2], TB[i/2], 3'b000);
      check("aluResult", {2'b0, i[0] ? TA[i/2] - TB[i/2] : TA[i/2] + TB[i/2]},
            {2'b0, aluResult});
    end
    for (int i = 0; i < 4; i++) begin
      expRes = i[0] ? {expSt[0], RA[i][7:1]} : {RA[i][6:0], expSt[0]};
      expSt[0] = i[0] ? RA[i][0] : RA[i][7];
      step(1'b0, CPPS_OP_STEP, 10'h0, i[0] ? CPPS_ALU_RRIGHT : CPPS_ALU_RLEFT,
           RA[i], 8'h00, 3'b000);
      check("aluResult", {2'b0, expRes}, {2'b0, aluResult});
    end
    expSt[2] = 1'b1;
    step(1'b0, CPPS_OP_STEP, 10'h0, CPPS_ALU_LOGIC, 8'h00, 8'h00, 3'b000);
    expSt[2] = 1'b0;
    step(1'b0, CPPS_OP_STEP, 10'h0, CPPS_ALU_LOGIC, 8'h3c, 8'h00, 3'b000);
    check("aluResult", 10'h03c, {2'b0, aluResult});
    // Reset again mid-run: counter, status and pointer return to reset values
    @(posedge clkSys);
    reset <= 1'b1;
    repeat (2) @(posedge clkSys);
    reset <= 1'b0;
    #1;
    check("programCounter", `CPPS_PC_RESET, programCounter);
    check("statusFlags", {2'b0, `CPPS_STATUS_RESET}, {2'b0, statusFlags});
    rd(PT, 8'hc0, "pointer");
    wrapUp();
  end
endmodule

/* cpps_pkg.sv */
// Types shared by the core pointer, counter and status register block
package cpps_pkg;
  typedef enum logic [2:0] {
    CPPS_OP_STEP,
    CPPS_OP_JUMP,
    CPPS_OP_CALL,
    CPPS_OP_RETURN,
    CPPS_OP_SLEEP,
    CPPS_OP_KICK
  } cpps_instr_t;

  typedef enum logic [2:0] {
    CPPS_ALU_NONE,
    CPPS_ALU_ADD,
    CPPS_ALU_SUB,
    CPPS_ALU_RLEFT,
    CPPS_ALU_RRIGHT,
    CPPS_ALU_LOGIC
  } cpps_alu_t;
endpackage
